//--- verilog/fco_command_object.sv
// fco_command_object: indexed command parameter store, completion flag and launch,
// data-flash protect size and a reserved zero register.
// assumes one 125 MHz clock, synchronous reset and an engine that pulses done.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - protect size code grows range from 0x10_0000 in 256-byte steps, top 0x10_1FFF
// - six 16-bit parameter words, selected by a three-bit index register
// - parameter word takes byte and word reads and writes, lanes independent
// - software loads words, then writing one to completion flag clears it and launches
// - parameter words are locked against software while the command runs
// - completion sets the flag again; results are valid only after that
// - index values 110 and 111 drop writes and read as zero
// - command code is the high byte of word 000
// - word 000 low byte holds zero then address 22:16; word 001 holds 15:0
// - words 010 to 101 carry data words zero to three, high byte high lane
// - reserved register reads zero and ignores writes
// - while flag is zero, no new launch and parameter writes are ignored
module fco_command_object (
	input wire logic clk, // bus clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic [3:0] reg_addr, // register word index
	input wire logic [15:0] reg_wdata, // write data
	input wire logic [1:0] reg_be, // byte enables, bit 1 is the high lane
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, cycle after the strobe
	output logic cmd_start, // one-cycle launch pulse to the engine
	output logic cmd_busy, // command running (flag reads zero)
	output logic [7:0] command_code, // command code
	output logic [22:0] cmd_gaddr, // global address
	output logic [63:0] cmd_data, // data words 3..0
	input wire logic eng_done, // engine finished, one-cycle pulse
	input wire logic eng_res_we, // engine writes a result word
	input wire logic [2:0] eng_res_idx, // result word index
	input wire logic [15:0] eng_res_data, // result word
	input wire logic [22:0] chk_addr, // address to test against protection
	output logic dfp_hit, // chk_addr is protected, one cycle late
	output logic [22:0] dfp_end, // last protected address
	output logic irq // level interrupt
);
	fco_pkg::fco_state_e state_q, state_d;
	logic [fco_pkg::NUM_WORDS-1:0][15:0] param_q, param_d;
	logic [2:0] index_q;
	logic [4:0] protect_size_q;
	logic [15:0] rdata_q, rd_mux;
	logic start_q;
	logic [22:0] end_q;
	logic hit_q;
	logic [22:0] end_w;
	logic hit_w;
	logic [1:0] irq_stat, irq_mask;
	logic irq_w;

	// address decode
	wire sel_stat = (reg_addr == fco_pkg::OFS_STAT);
	wire sel_index = (reg_addr == fco_pkg::OFS_INDEX);
	wire sel_param = (reg_addr == fco_pkg::OFS_PARAM);
	wire sel_protect = (reg_addr == fco_pkg::OFS_PROTECT);
	wire sel_rsv0 = (reg_addr == fco_pkg::OFS_RSV0);
	wire sel_istat = (reg_addr == fco_pkg::OFS_IRQ_STAT);
	wire sel_imask = (reg_addr == fco_pkg::OFS_IRQ_MASK);

	wire complete_flag = (state_q == fco_pkg::ST_IDLE);
	wire idx_valid = (index_q <= fco_pkg::IDX_LAST);

	// launch only from idle, by a one in the flag bit of the low lane
	wire launch = reg_wr && sel_stat && reg_be[0] && complete_flag
		&& reg_wdata[fco_pkg::COMPLETE_FLAG_BIT];
	wire finish = !complete_flag && eng_done;

	// software writes land only while idle and on an implemented index
	wire sw_param_wr = reg_wr && sel_param && complete_flag && idx_valid;
	wire locked_wr = reg_wr && sel_param && !complete_flag;
	wire eng_wr = !complete_flag && eng_res_we;

	// completion flag state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			fco_pkg::ST_IDLE: begin
				if (launch) begin
					state_d = fco_pkg::ST_BUSY;
				end
			end
			fco_pkg::ST_BUSY: begin
				if (eng_done) begin
					state_d = fco_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// per-word next value; engine results win, they only arrive while locked
	genvar gi;
	generate
		for (gi = 0; gi < fco_pkg::NUM_WORDS; gi++) begin : g_word
			wire sw_hit = sw_param_wr && (index_q == 3'(gi));
			wire en_hit = eng_wr && (eng_res_idx == 3'(gi));
			logic [15:0] sw_val;
			always_comb begin
				sw_val = param_q[gi];
				if (reg_be[1]) begin
					sw_val[15:8] = reg_wdata[15:8];
				end
				if (reg_be[0]) begin
					sw_val[7:0] = reg_wdata[7:0];
				end
				if (gi == 0) begin
					sw_val[fco_pkg::ADDR_HI_ZERO_BIT] = 1'b0;
				end
			end
			always_comb begin
				param_d[gi] = param_q[gi];
				if (en_hit) begin
					param_d[gi] = eng_res_data;
				end else if (sw_hit) begin
					param_d[gi] = sw_val;
				end
			end
		end
	endgenerate

	// read selection; unimplemented indices and unmapped offsets return zero
	wire [15:0] param_rd = idx_valid ? param_q[index_q] : fco_pkg::RD_ZERO;
	assign rd_mux = sel_stat ? {8'h00, complete_flag, 7'h00} :
		sel_index ? {13'h0000, index_q} :
		sel_param ? param_rd :
		sel_protect ? {11'h000, protect_size_q} :
		sel_rsv0 ? fco_pkg::RD_ZERO :
		sel_istat ? {14'h0000, irq_stat} :
		sel_imask ? {14'h0000, irq_mask} :
		fco_pkg::RD_ZERO;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= fco_pkg::ST_IDLE;
			param_q <= '0;
			index_q <= fco_pkg::INDEX_RST;
			start_q <= 1'b0;
		end else begin
			state_q <= state_d;
			param_q <= param_d;
			start_q <= launch;
			if (reg_wr && sel_index && reg_be[0]) begin
				index_q <= reg_wdata[2:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			protect_size_q <= fco_pkg::PROTECT_RST;
			rdata_q <= fco_pkg::RD_ZERO;
			end_q <= fco_pkg::DFP_BASE;
			hit_q <= 1'b0;
		end else begin
			if (reg_wr && sel_protect && reg_be[0]) begin
				protect_size_q <= reg_wdata[4:0];
			end
			// read data stands only in the cycle after the strobe
			rdata_q <= reg_rd ? rd_mux : fco_pkg::RD_ZERO;
			end_q <= end_w;
			hit_q <= hit_w;
		end
	end

	fco_protect_range u_range (
		.protect_size(protect_size_q),
		.chk_addr(chk_addr),
		.end_addr(end_w),
		.hit(hit_w)
	);

	fco_irq u_irq (
		.clk(clk),
		.sys_rst(sys_rst),
		.event_in({locked_wr, finish}),
		.stat_rd(reg_rd && sel_istat),
		.mask_wr(reg_wr && sel_imask && reg_be[0]),
		.mask_wdata(reg_wdata[1:0]),
		.stat_q(irq_stat),
		.mask_q(irq_mask),
		.irq_q(irq_w)
	);

	assign reg_rdata = rdata_q;
	assign cmd_start = start_q;
	assign cmd_busy = (state_q == fco_pkg::ST_BUSY);
	assign command_code = param_q[fco_pkg::IDX_CMD][15:8];
	assign cmd_gaddr = {param_q[fco_pkg::IDX_CMD][6:0], param_q[fco_pkg::IDX_ADDR]};
	assign cmd_data = {param_q[5], param_q[4], param_q[3], param_q[fco_pkg::IDX_DATA0]};
	assign dfp_hit = hit_q;
	assign dfp_end = end_q;
	assign irq = irq_w;

	// checks

	launch_clears_flag_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_stat && reg_be[0] && reg_wdata[7] && complete_flag)
		|=> (cmd_busy && cmd_start) ##1 !cmd_start)
		else $error("launch write did not clear the flag and pulse start");

	params_locked_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cmd_busy && !eng_res_we) |=> $stable(param_q))
		else $error("parameter words changed while locked");

	done_sets_flag_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cmd_busy && eng_done) |=> !cmd_busy && !cmd_start)
		else $error("completion did not return the flag to one");

	unused_index_zero_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_param && index_q[2] && index_q[1]) |=> (reg_rdata == 16'h0000))
		else $error("unimplemented index read not zero");

	index_select_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_param && index_q < 3'h6) |=> (reg_rdata == $past(param_q[index_q])))
		else $error("parameter read did not follow the index");

	byte_lane_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_param && complete_flag && reg_be == 2'b01 && index_q == 3'h2)
		|=> (param_q[2][15:8] == $past(param_q[2][15:8]))
		&& (param_q[2][7:0] == $past(reg_wdata[7:0])))
		else $error("low-lane write disturbed the high byte");

	code_from_word0_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_param && complete_flag && index_q == 3'h0 && reg_be[1])
		|=> (command_code == $past(reg_wdata[15:8])))
		else $error("command code not taken from word 000 high byte");

	addr_zero_bit_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_param && complete_flag && index_q == 3'h0 && reg_be[0])
		|=> (param_q[0][7] == 1'b0) && (cmd_gaddr[22:16] == $past(reg_wdata[6:0])))
		else $error("address byte of word 000 not stored as zero plus 22:16");

	reserved_zero_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_rsv0) |=> (reg_rdata == 16'h0000))
		else $error("reserved register read not zero");

	busy_ignores_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cmd_busy && reg_wr && !eng_res_we) |=> !cmd_start && $stable(param_q))
		else $error("write while busy was not ignored");

	top_protect_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(protect_size_q == 5'h1f) [*2] |-> (dfp_end == 23'h10_1fff))
		else $error("top protect code does not end at 0x10_1FFF");

	reset_clears_a: assert property (
		@(posedge clk)
		sys_rst |=> (index_q == 3'h0) && (param_q == '0) && !cmd_busy)
		else $error("reset did not clear index and parameter words");

	index_write_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_index && reg_be[0]) |=> (index_q == $past(reg_wdata[2:0])))
		else $error("index register did not take the written value");

	result_write_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cmd_busy && eng_res_we && eng_res_idx == 3'h2) |=> (param_q[2] == $past(eng_res_data)))
		else $error("engine result did not reach word 010");

	flag_read_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_rd && sel_stat) |=> (reg_rdata[7] == !$past(cmd_busy)))
		else $error("completion flag read does not mirror the running command");

	locked_event_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(cmd_busy && reg_wr && sel_param) |=> irq_stat[fco_pkg::IRQ_LOCKED_BIT])
		else $error("write while busy did not set its status bit");

	idle_engine_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(!cmd_busy && !reg_wr) |=> !cmd_busy && $stable(param_q))
		else $error("engine input changed state while idle");

	rdata_idle_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		!reg_rd |=> (reg_rdata == 16'h0000))
		else $error("read data stood outside the cycle after a read");

	protect_write_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(reg_wr && sel_protect && reg_be[0])
		|=> ##1 (dfp_end[12:8] == $past(reg_wdata[4:0], 2)) && (dfp_end[7:0] == 8'hff))
		else $error("protect size write did not move the range end");

	protect_hit_a: assert property (
		@(posedge clk) disable iff (sys_rst)
		(chk_addr < fco_pkg::DFP_BASE) |=> !dfp_hit)
		else $error("address below the protected range reported as hit");

endmodule
`default_nettype wire

//--- verilog/fco_pkg.sv
// fco_pkg: constants and types shared by the flash command object block.
// assumes one clock, a synchronous active-high reset and word-indexed register offsets.
package fco_pkg;

	// register offsets on the plain register port (word index)
	localparam logic [3:0] OFS_STAT = 4'h0;
	localparam logic [3:0] OFS_INDEX = 4'h1;
	localparam logic [3:0] OFS_PARAM = 4'h2;
	localparam logic [3:0] OFS_PROTECT = 4'h3;
	localparam logic [3:0] OFS_RSV0 = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h6;

	// field positions
	localparam int COMPLETE_FLAG_BIT = 7;
	localparam int ADDR_HI_ZERO_BIT = 7;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_LOCKED_BIT = 1;
	localparam int IRQ_W = 2;

	// parameter array shape and word indices
	localparam int NUM_WORDS = 6;
	localparam int IDX_W = 3;
	localparam logic [2:0] IDX_CMD = 3'h0;
	localparam logic [2:0] IDX_ADDR = 3'h1;
	localparam logic [2:0] IDX_DATA0 = 3'h2;
	localparam logic [2:0] IDX_LAST = 3'h5;

	// data-flash protection: base address, 256-byte steps
	localparam int PROTECT_W = 5;
	localparam int GADDR_W = 23;
	localparam logic [22:0] DFP_BASE = 23'h10_0000;
	localparam logic [7:0] DFP_STEP_FILL = 8'hff;
	localparam logic [22:0] DFP_TOP_END = 23'h10_1fff;
	localparam logic [4:0] PROTECT_TOP = 5'h1f;

	// values after reset
	localparam logic [15:0] PARAM_RST = 16'h0000;
	localparam logic [2:0] INDEX_RST = 3'h0;
	localparam logic [4:0] PROTECT_RST = 5'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam logic [15:0] RD_ZERO = 16'h0000;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} fco_state_e;

endpackage

//--- verilog/fco_protect_range.sv
// fco_protect_range: end address of the protected data-flash range and a hit check.
// assumes the caller registers the outputs; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module fco_protect_range (
	input wire logic [4:0] protect_size, // protect size code
	input wire logic [22:0] chk_addr, // global address to test
	output logic [22:0] end_addr, // last protected address
	output logic hit // chk_addr lies in the protected range
);
	// base has its low 13 bits clear, so or-ing the code in is an exact add
	assign end_addr = fco_pkg::DFP_BASE | {10'h000, protect_size, fco_pkg::DFP_STEP_FILL};
	assign hit = (chk_addr >= fco_pkg::DFP_BASE) && (chk_addr <= end_addr);
endmodule
`default_nettype wire

//--- verilog/fco_irq.sv
// fco_irq: sticky event status, mask and one level interrupt.
// assumes events are one-cycle pulses; a status read clears the bits it returned.
`timescale 1ns/1ps
`default_nettype none
module fco_irq (
	input wire logic clk, // bus clock
	input wire logic sys_rst, // synchronous reset
	input wire logic [1:0] event_in, // event pulses
	input wire logic stat_rd, // status register read
	input wire logic mask_wr, // mask register write
	input wire logic [1:0] mask_wdata, // new mask
	output logic [1:0] stat_q, // sticky status
	output logic [1:0] mask_q, // mask
	output logic irq_q // level interrupt
);
	logic [1:0] stat_d;
	logic irq_d;

	// an event in the clearing cycle survives the clear
	assign stat_d = (stat_rd ? fco_pkg::IRQ_RST : stat_q) | event_in;
	assign irq_d = |(stat_d & mask_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_q <= fco_pkg::IRQ_RST;
			mask_q <= fco_pkg::IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			if (mask_wr) begin
				mask_q <= mask_wdata;
			end
			irq_q <= mask_wr ? |(stat_d & mask_wdata) : irq_d;
		end
	end

	irq_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
		(event_in[0] && mask_q[0] && !mask_wr) |=> irq_q)
		else $error("unmasked event did not raise the interrupt");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// testbench: register-level self-checking bench for fco_command_object.
// assumes the plain register port, read data one cycle after the strobe, one 8 ns clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [1:0] reg_be = 2'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic eng_done = 1'b0;
	logic eng_res_we = 1'b0;
	logic [2:0] eng_res_idx = 3'h0;
	logic [15:0] eng_res_data = 16'h0000;
	logic [22:0] chk_addr = 23'h00_0000;
	logic [15:0] reg_rdata;
	logic cmd_start, cmd_busy, dfp_hit, irq;
	logic [7:0] command_code;
	logic [22:0] cmd_gaddr, dfp_end, e;
	logic [63:0] cmd_data;
	logic [15:0] d;
	logic [15:0] w [6] = '{16'ha5ff, 16'h1234, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
	logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h15, 5'h1f};
	int n_mismatch = 0;
	int checked = 0;

	always #4 clk = ~clk;

	fco_command_object i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .cmd_start(cmd_start), .cmd_busy(cmd_busy),
		.command_code(command_code), .cmd_gaddr(cmd_gaddr), .cmd_data(cmd_data),
		.eng_done(eng_done), .eng_res_we(eng_res_we), .eng_res_idx(eng_res_idx),
		.eng_res_data(eng_res_data), .chk_addr(chk_addr), .dfp_hit(dfp_hit),
		.dfp_end(dfp_end), .irq(irq));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// each access leaves one idle cycle so a strobe is never lowered and raised in one step
	task automatic wr(input logic [3:0] a, input logic [15:0] v, input logic [1:0] be);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_be <= be;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_be <= 2'h3;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic setp(input logic [2:0] i, input logic [15:0] v, input logic [1:0] be);
		wr(fco_pkg::OFS_INDEX, {13'h0000, i}, 2'h1);
		wr(fco_pkg::OFS_PARAM, v, be);
	endtask

	task automatic getp(input logic [2:0] i, input logic [15:0] exp, input string nm);
		logic [15:0] v;
		wr(fco_pkg::OFS_INDEX, {13'h0000, i}, 2'h1);
		rd(fco_pkg::OFS_PARAM, v);
		chk(nm, v, exp);
	endtask

	task automatic launch(input logic exp);
		wr(fco_pkg::OFS_STAT, 16'h0080, 2'h1);
		#1;
		chk("cmd_start", cmd_start, exp);
	endtask

	task automatic finish_cmd(input logic [2:0] i, input logic [15:0] v);
		@(posedge clk);
		eng_res_we <= 1'b1;
		eng_res_idx <= i;
		eng_res_data <= v;
		eng_done <= 1'b1;
		@(posedge clk);
		eng_res_we <= 1'b0;
		eng_done <= 1'b0;
		#1;
		chk("busy_after_done", cmd_busy, 1'b0);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd(fco_pkg::OFS_INDEX, d);
		chk("index_rst", d[2:0], 3'h0);
		for (int i = 0; i < 6; i++)
			getp(3'(i), 16'h0000, "word_rst");
		rd(fco_pkg::OFS_STAT, d);
		chk("flag_idle", d[7], 1'b1);
		chk("dfp_end_rst", dfp_end, 23'h10_00ff);
		for (int i = 0; i < 6; i++)
			setp(3'(i), w[i], 2'h3);
		for (int i = 0; i < 6; i++)
			getp(3'(i), (i == 0) ? 16'ha57f : w[i], "word_rdback");
		chk("command_code", command_code, 8'ha5);
		chk("cmd_gaddr", cmd_gaddr, {7'h7f, 16'h1234});
		chk("cmd_data", cmd_data, 64'h5555_4444_3333_2222);
		setp(3'h2, 16'h00aa, 2'h1);
		getp(3'h2, 16'h22aa, "low_lane");
		setp(3'h2, 16'h5500, 2'h2);
		getp(3'h2, 16'h55aa, "high_lane");
		for (int i = 6; i < 8; i++) begin
			setp(3'(i), 16'hffff, 2'h3);
			getp(3'(i), 16'h0000, "unused_word");
		end
		wr(fco_pkg::OFS_RSV0, 16'h00ff, 2'h1);
		rd(fco_pkg::OFS_RSV0, d);
		chk("reserved", d, 16'h0000);
		rd(4'hf, d);
		chk("unmapped", d, 16'h0000);
		// protected range: last address inside, one past it and one below the base outside
		foreach (codes[k]) begin
			wr(fco_pkg::OFS_PROTECT, {11'h000, codes[k]}, 2'h1);
			e = fco_pkg::DFP_BASE + {10'h000, codes[k], 8'hff};
			repeat (2) @(posedge clk);
			#1;
			chk("dfp_end", dfp_end, e);
			@(posedge clk);
			chk_addr <= e;
			repeat (2) @(posedge clk);
			#1;
			chk("dfp_hit_end", dfp_hit, 1'b1);
			@(posedge clk);
			chk_addr <= e + 23'h00_0001;
			repeat (2) @(posedge clk);
			#1;
			chk("dfp_hit_past", dfp_hit, 1'b0);
			@(posedge clk);
			chk_addr <= fco_pkg::DFP_BASE - 23'h00_0001;
			repeat (2) @(posedge clk);
			#1;
			chk("dfp_hit_below", dfp_hit, 1'b0);
		end
		wr(fco_pkg::OFS_IRQ_MASK, 16'h0003, 2'h1);
		launch(1'b1);
		chk("busy", cmd_busy, 1'b1);
		rd(fco_pkg::OFS_STAT, d);
		chk("flag_cleared", d[7], 1'b0);
		setp(3'h2, 16'h1234, 2'h3);
		getp(3'h2, 16'h55aa, "locked_word");
		chk("irq_locked_write", irq, 1'b1);
		launch(1'b0);
		finish_cmd(3'h2, 16'hbeef);
		rd(fco_pkg::OFS_STAT, d);
		chk("flag_set", d[7], 1'b1);
		getp(3'h2, 16'hbeef, "result_word");
		rd(fco_pkg::OFS_IRQ_STAT, d);
		chk("irq_stat", d[1:0], 2'h3);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_cleared", irq, 1'b0);
		// engine writes outside a command must not reach the store
		@(posedge clk);
		eng_res_we <= 1'b1;
		eng_res_idx <= 3'h3;
		@(posedge clk);
		eng_res_we <= 1'b0;
		getp(3'h3, 16'h3333, "idle_engine");
		wr(fco_pkg::OFS_IRQ_MASK, 16'h0000, 2'h1);
		launch(1'b1);
		finish_cmd(3'h5, 16'h0f0f);
		repeat (3) @(posedge clk);
		#1;
		chk("irq_masked", irq, 1'b0);
		rd(fco_pkg::OFS_IRQ_STAT, d);
		chk("irq_stat_done", d[1:0], 2'h1);
		getp(3'h5, 16'h0f0f, "result_word5");
		chk("cmd_data_result", cmd_data[63:48], 16'h0f0f);
		wrap_up();
	end

	// the sequence takes well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch = n_mismatch + 1;
		wrap_up();
	end
endmodule
`default_nettype wire
